/* common/sab_pkg.sv */
package sab_pkg;

    // Register offsets on the plain register port
    localparam logic [1:0] SAB_OFS_CTL = 2'h0;
    localparam logic [1:0] SAB_OFS_CNT = 2'h1;
    localparam logic [1:0] SAB_OFS_CFG = 2'h2;

    // Control/status field positions
    localparam int SAB_CTL_MODE_HI = 7;
    localparam int SAB_CTL_MODE_LO = 6;
    localparam int SAB_CTL_LOST = 5;
    localparam int SAB_CTL_CLKSEL = 4;
    localparam int SAB_CTL_DONE = 3;
    localparam int SAB_CTL_RUN = 2;
    localparam int SAB_CTL_OVF = 1;
    localparam int SAB_CTL_MSB = 0;

    // Configuration field position
    localparam int SAB_CFG_PSRC = 0;

    // Mode codes
    localparam logic [1:0] SAB_MODE_IDLE = 2'h0;
    localparam logic [1:0] SAB_MODE_MEAS = 2'h1;
    localparam logic [1:0] SAB_MODE_ARB = 2'h2;

    // Reset values
    localparam logic [1:0] SAB_RST_MODE = 2'h0;
    localparam logic SAB_RST_CLKSEL = 1'b0;
    localparam logic SAB_RST_PSRC = 1'b0;
    localparam logic [8:0] SAB_RST_CNT = 9'h000;
    localparam logic [7:0] SAB_RST_RDATA = 8'h00;

    // Timing counts
    localparam logic [1:0] SAB_DIV4_LAST = 2'h3;
    localparam logic [8:0] SAB_SMP_QBUS = 9'h038;
    localparam logic [8:0] SAB_SMP_PRESC = 9'h008;

    typedef enum logic [2:0] {
        SAB_ST_IDLE,
        SAB_ST_MEAS_WAIT,
        SAB_ST_MEAS_RUN,
        SAB_ST_MEAS_DONE,
        SAB_ST_ARB_WAIT,
        SAB_ST_ARB_RUN
    } sab_state_e;

endpackage

/* rtl/sab_top.sv */
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// RULE1: Nine-bit counter plus separate overflow bit.
// RULE2: Mode field: idle, measure, arbitrate; 11 reserved.
// RULE3: Mode 00 holds counter reset while selected.
// RULE4: Clock select: half prescaler or quarter bus.
// RULE5: Prescaler source bit picks bus or quad clock.
// RULE6: Lost flag cleared by writing upper mode zero.
// RULE7: Done flag set on finish, cleared by write.
// RULE8: Running flag shows counter counting or stopped.
// RULE9: Overflow flag set on wrap, cleared by write.
// RULE10: Counter MSB readable, cleared by control write.
// RULE11: Low count bits readable, cleared by write.
// RULE12: Quarter-clock measure: falling edge to falling edge.
// RULE13: Running between edges, done at second fall.
// RULE14: Prescaler measure starts while receive line low.
// RULE15: Prescaler measure stops at next rising edge.
// RULE16: Arbitration restarts counter on transmit rising edge.
// RULE17: Sample receive at 38 or 08; low sets lost.
// RULE18: Lost flag forces transmit pin high.
// RULE19: Transmit low before receive low restarts arbitration.
// RULE20: Reads have no side effects.
module sab_top
    import sab_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic rx_pin,
    input wire logic tx_shift_out,
    input wire logic presc_tick,
    output logic tx_pin,
    output logic prescaler_src_sel
);

    ////////////////////////////////////////////////////////////////////////////
    // Decode helpers

    function automatic sab_state_e start_state(input logic [1:0] mode);
        unique case (mode)
            SAB_MODE_MEAS: start_state = SAB_ST_MEAS_WAIT;
            SAB_MODE_ARB: start_state = SAB_ST_ARB_WAIT;
            default: start_state = SAB_ST_IDLE;
        endcase
    endfunction

    function automatic logic [8:0] sample_point(input logic sel);
        sample_point = sel ? SAB_SMP_PRESC : SAB_SMP_QBUS;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and signals

    logic [1:0] mode_r;
    logic clk_sel_r;
    logic psrc_r;
    logic lost_r;
    logic lost_nxt;
    logic done_r;
    logic done_nxt;
    logic ovf_r;
    logic ovf_nxt;
    logic [8:0] cnt_r;
    logic [8:0] cnt_nxt;
    logic [9:0] cnt_inc;
    sab_state_e state_r;
    sab_state_e state_nxt;
    logic rx_s1_r;
    logic rx_s2_r;
    logic rx_s3_r;
    logic rx_level_r;
    logic tx_prev_r;
    logic [1:0] div4_r;
    logic presc_half_r;
    logic rx_low_seen_r;
    logic sampled_r;
    logic [7:0] rdata_r;
    logic tx_pin_r;

    logic ctl_wr;
    logic cfg_wr;
    logic rx_stable;
    logic rx_fall;
    logic rx_rise;
    logic tx_rise;
    logic tx_fall;
    logic tick;
    logic running;
    logic cnt_clr;
    logic done_set;
    logic sample_hit;
    logic abort_bit;

    assign ctl_wr = reg_wr && (reg_addr == SAB_OFS_CTL);
    assign cfg_wr = reg_wr && (reg_addr == SAB_OFS_CFG);

    ////////////////////////////////////////////////////////////////////////////
    // Receive pin synchroniser and edges

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
        end
    end

    // Level only moves once the last two stages agree
    assign rx_stable = (rx_s2_r == rx_s3_r);
    assign rx_fall = rx_stable && rx_level_r && !rx_s2_r;
    assign rx_rise = rx_stable && !rx_level_r && rx_s2_r;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_level_r <= 1'b1;
        end else if (rx_stable) begin
            rx_level_r <= rx_s2_r;
        end
    end

    // Transmit shift output is on our clock, no synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_prev_r <= 1'b1;
        end else begin
            tx_prev_r <= tx_shift_out;
        end
    end

    assign tx_rise = tx_shift_out && !tx_prev_r;
    assign tx_fall = !tx_shift_out && tx_prev_r;

    ////////////////////////////////////////////////////////////////////////////
    // Counter clock sources

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div4_r <= 2'h0;
        end else begin
            div4_r <= div4_r + 2'h1;
        end
    end

    // Halves the prescaler pulse stream
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            presc_half_r <= 1'b0;
        end else if (presc_tick) begin
            presc_half_r <= !presc_half_r;
        end
    end

    assign tick = clk_sel_r ? (presc_tick && presc_half_r)
                            : (div4_r == SAB_DIV4_LAST); // [RULE4]

    ////////////////////////////////////////////////////////////////////////////
    // Software registers

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            mode_r <= SAB_RST_MODE;
            clk_sel_r <= SAB_RST_CLKSEL;
        end else if (ctl_wr) begin
            mode_r <= reg_wdata[SAB_CTL_MODE_HI:SAB_CTL_MODE_LO]; // [RULE2]
            clk_sel_r <= reg_wdata[SAB_CTL_CLKSEL]; // [RULE4]
        end
    end

    // Source bit steers the external prescaler
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            psrc_r <= SAB_RST_PSRC;
        end else if (cfg_wr) begin
            psrc_r <= reg_wdata[SAB_CFG_PSRC]; // [RULE5]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencer

    always_comb begin
        state_nxt = state_r;
        cnt_clr = 1'b0;
        done_set = 1'b0;
        abort_bit = 1'b0;
        unique case (state_r)
            SAB_ST_IDLE: begin
                cnt_clr = 1'b1; // [RULE3]
            end
            SAB_ST_MEAS_WAIT: begin
                if (clk_sel_r ? !rx_level_r : rx_fall) begin
                    state_nxt = SAB_ST_MEAS_RUN; // [RULE12] [RULE14]
                end
            end
            SAB_ST_MEAS_RUN: begin
                if (clk_sel_r ? rx_rise : rx_fall) begin
                    state_nxt = SAB_ST_MEAS_DONE; // [RULE12] [RULE15]
                    done_set = 1'b1; // [RULE13]
                end
            end
            SAB_ST_MEAS_DONE: begin
                state_nxt = SAB_ST_MEAS_DONE;
            end
            SAB_ST_ARB_WAIT: begin
                if (tx_rise) begin
                    state_nxt = SAB_ST_ARB_RUN;
                    cnt_clr = 1'b1; // [RULE16]
                end
            end
            SAB_ST_ARB_RUN: begin
                if (tx_rise) begin
                    cnt_clr = 1'b1; // [RULE16]
                end else if (tx_fall && !rx_low_seen_r && rx_level_r) begin
                    state_nxt = SAB_ST_ARB_WAIT; // [RULE19]
                    cnt_clr = 1'b1;
                    abort_bit = 1'b1;
                end
            end
            default: begin
                state_nxt = SAB_ST_IDLE;
            end
        endcase
        // A control write restarts whatever mode it selects
        if (ctl_wr) begin
            state_nxt = start_state(reg_wdata[SAB_CTL_MODE_HI:SAB_CTL_MODE_LO]); // [RULE2]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SAB_ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign running = (state_r == SAB_ST_MEAS_RUN) || (state_r == SAB_ST_ARB_RUN); // [RULE8]

    ////////////////////////////////////////////////////////////////////////////
    // Counter with overflow

    assign cnt_inc = {1'b0, cnt_r} + 10'h001;

    always_comb begin
        cnt_nxt = cnt_r;
        ovf_nxt = ovf_r;
        if (ctl_wr || cnt_clr) begin
            cnt_nxt = SAB_RST_CNT; // [RULE10] [RULE11] [RULE3]
        end else if (running && tick) begin
            cnt_nxt = cnt_inc[8:0]; // [RULE1]
        end
        // Overflow event beats a clearing write
        if (!cnt_clr && running && tick && cnt_inc[9]) begin
            ovf_nxt = 1'b1; // [RULE9]
        end else if (ctl_wr) begin
            ovf_nxt = 1'b0; // [RULE9]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= SAB_RST_CNT;
            ovf_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            ovf_r <= ovf_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Measurement finish flag

    // A finish in the clearing cycle survives the write; the set wins
    assign done_nxt = done_set || (done_r && !ctl_wr); // [RULE7]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            done_r <= 1'b0;
        end else begin
            done_r <= done_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arbitration sampling

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rx_low_seen_r <= 1'b0;
        end else if (ctl_wr || tx_rise || abort_bit) begin
            rx_low_seen_r <= 1'b0;
        end else if (state_r == SAB_ST_ARB_RUN && !rx_level_r) begin
            rx_low_seen_r <= 1'b1; // [RULE19]
        end
    end

    // One static look per bit, at the first cycle of the sample count
    assign sample_hit = (state_r == SAB_ST_ARB_RUN) && !sampled_r &&
                        (cnt_r == sample_point(clk_sel_r)); // [RULE17]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sampled_r <= 1'b0;
        end else if (ctl_wr || cnt_clr) begin
            sampled_r <= 1'b0;
        end else if (sample_hit) begin
            sampled_r <= 1'b1;
        end
    end

    // Loss seen in the clearing cycle survives the write
    assign lost_nxt = (sample_hit && !rx_level_r) ||
                      (lost_r && !(ctl_wr && !reg_wdata[SAB_CTL_MODE_HI])); // [RULE6] [RULE17]

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lost_r <= 1'b0;
        end else begin
            lost_r <= lost_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tx_pin_r <= 1'b1;
        end else begin
            tx_pin_r <= tx_shift_out || lost_nxt; // [RULE18]
        end
    end

    // Read path is pure observation
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata_r <= SAB_RST_RDATA;
        end else if (reg_rd) begin
            unique case (reg_addr)
                SAB_OFS_CTL: rdata_r <= {mode_r, lost_r, clk_sel_r, done_r,
                                         running, ovf_r, cnt_r[8]}; // [RULE10] [RULE20]
                SAB_OFS_CNT: rdata_r <= cnt_r[7:0]; // [RULE11] [RULE20]
                SAB_OFS_CFG: rdata_r <= {7'h00, psrc_r};
                default: rdata_r <= SAB_RST_RDATA;
            endcase
        end else begin
            rdata_r <= SAB_RST_RDATA;
        end
    end

    assign reg_rdata = rdata_r;
    assign tx_pin = tx_pin_r;
    assign prescaler_src_sel = psrc_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_meas_start;
        state_r == SAB_ST_MEAS_RUN && !ctl_wr;
    endsequence

    sequence s_meas_stop;
        state_r == SAB_ST_MEAS_DONE;
    endsequence

    property p_idle_hold;
        @(posedge clk) disable iff (!nrst)
        (state_r == SAB_ST_IDLE) |=> (cnt_r == 9'h000);
    endproperty
    a_idle_hold: assert property (p_idle_hold) else $error("idle count not zero"); // [RULE3]

    property p_wr_clears;
        @(posedge clk) disable iff (!nrst)
        ctl_wr |=> (cnt_r == 9'h000) && (!done_r || $past(done_set));
    endproperty
    a_wr_clears: assert property (p_wr_clears) else $error("write did not clear"); // [RULE7]

    property p_run_flag;
        @(posedge clk) disable iff (!nrst)
        (running && tick && !ctl_wr && !cnt_clr) |=> (cnt_r == $past(cnt_r) + 9'h001);
    endproperty
    a_run_flag: assert property (p_run_flag) else $error("running counter stuck"); // [RULE8]

    property p_stop_hold;
        @(posedge clk) disable iff (!nrst)
        (s_meas_stop ##1 s_meas_stop) |-> $stable(cnt_r);
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved"); // [RULE12]

    property p_done_on_stop;
        @(posedge clk) disable iff (!nrst)
        (s_meas_start ##1 s_meas_stop) |-> done_r;
    endproperty
    a_done_on_stop: assert property (p_done_on_stop) else $error("finish flag missing"); // [RULE13]

    property p_presc_start;
        @(posedge clk) disable iff (!nrst)
        (state_r == SAB_ST_MEAS_WAIT && clk_sel_r && !rx_level_r && !ctl_wr)
            |=> state_r == SAB_ST_MEAS_RUN;
    endproperty
    a_presc_start: assert property (p_presc_start) else $error("low rx did not start"); // [RULE14]

    property p_lost_force;
        @(posedge clk) disable iff (!nrst)
        lost_r |-> tx_pin_r;
    endproperty
    a_lost_force: assert property (p_lost_force) else $error("tx not forced high"); // [RULE18]

    property p_arb_restart;
        @(posedge clk) disable iff (!nrst)
        (state_r == SAB_ST_ARB_RUN && tx_rise && !ctl_wr) |=> (cnt_r == 9'h000);
    endproperty
    a_arb_restart: assert property (p_arb_restart) else $error("tx rise no restart"); // [RULE16]

    property p_lost_set;
        @(posedge clk) disable iff (!nrst)
        (sample_hit && !rx_level_r) |=> lost_r && tx_pin_r;
    endproperty
    a_lost_set: assert property (p_lost_set) else $error("loss not flagged"); // [RULE17]

    property p_lost_clear;
        @(posedge clk) disable iff (!nrst)
        (ctl_wr && !reg_wdata[SAB_CTL_MODE_HI] && !sample_hit) |=> !lost_r;
    endproperty
    a_lost_clear: assert property (p_lost_clear) else $error("lost not cleared"); // [RULE6]

    property p_ovf;
        @(posedge clk) disable iff (!nrst)
        (running && tick && cnt_r == 9'h1ff && !ctl_wr && !cnt_clr) |=> ovf_r;
    endproperty
    a_ovf: assert property (p_ovf) else $error("overflow not set"); // [RULE9]

    property p_abort;
        @(posedge clk) disable iff (!nrst)
        (abort_bit && !ctl_wr) |=> state_r == SAB_ST_ARB_WAIT && cnt_r == 9'h000;
    endproperty
    a_abort: assert property (p_abort) else $error("early tx low not restarted"); // [RULE19]

endmodule

/* tb/sab_peer.sv */
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Other transmitter on the shared line; pull-up, any party pulling low wins
module sab_peer (
    input wire logic tx_line,
    input wire logic hear_tx,
    input wire logic drive_low,
    output logic rx_line
);
    // Own echo is delayed by the pin register and the input sync
    assign rx_line = (tx_line | ~hear_tx) & ~drive_low;
endmodule

/* tb/test_sab_top.sv */
`timescale 1ns/1ps
module test_sab_top;
    import sab_pkg::*;
    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic [1:0] raddr;
        logic [7:0] exp;
        logic psrc;
    } sab_row_s;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic rx_pin;
    logic tx_shift_out = 1'b1;
    logic presc_tick = 1'b0;
    logic tx_pin;
    logic prescaler_src_sel;
    logic peer_low = 1'b0;
    logic hear_tx = 1'b1;
    logic [7:0] rd_val;
    logic [7:0] lo_val;
    logic [8:0] cnt_val;
    int errors = 0;
    int check_count = 0;
    int tick_div = 0;
    sab_row_s rows [9];

    always #2.5 clk = ~clk;

    // Prescaler stand-in: one tick every third clock
    always @(posedge clk) begin
        tick_div <= (tick_div == 2) ? 0 : tick_div + 1;
        presc_tick <= (tick_div == 2);
    end

    sab_top dut_u (
        .clk(clk),
        .nrst(nrst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .rx_pin(rx_pin),
        .tx_shift_out(tx_shift_out),
        .presc_tick(presc_tick),
        .tx_pin(tx_pin),
        .prescaler_src_sel(prescaler_src_sel)
    );

    sab_peer peer_u (
        .tx_line(tx_pin),
        .hear_tx(hear_tx),
        .drive_low(peer_low),
        .rx_line(rx_pin)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Counter clock phase is free, so counts are checked in a window
    task automatic chkr(input logic [8:0] got, input int lo, input int hi);
        logic ok;
        ok = (got >= lo) && (got <= hi);
        check_count++;
        if (ok !== 1'b1) begin
            errors++;
            $display("BAD %0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic rdcnt(output logic [8:0] c);
        rd(SAB_OFS_CTL, rd_val);
        rd(SAB_OFS_CNT, lo_val);
        c = {rd_val[SAB_CTL_MSB], lo_val};
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic meas0(input int gap, input int exp, input logic ovf);
        logic [8:0] c;
        wr(SAB_OFS_CTL, 8'h40);
        peer_low <= 1'b1;
        repeat (8) @(posedge clk);
        peer_low <= 1'b0;
        repeat (12) @(posedge clk);
        rd(SAB_OFS_CTL, rd_val);
        chk8(rd_val & 8'h0c, 8'h04);
        repeat (gap - 22) @(posedge clk);
        peer_low <= 1'b1;
        repeat (8) @(posedge clk);
        peer_low <= 1'b0;
        repeat (10) @(posedge clk);
        rdcnt(c);
        chk8(rd_val & 8'h0e, {4'h0, 1'b1, 1'b0, ovf, 1'b0});
        chkr(c, exp - 2, exp + 2);
        repeat (40) @(posedge clk);
        rd(SAB_OFS_CNT, lo_val);
        chkr({c[8], lo_val}, exp - 2, exp + 2);
    endtask

    task automatic arb(input logic [7:0] ctl, input int t_pre, input int t_post,
                       input logic drive);
        wr(SAB_OFS_CTL, ctl);
        tx_shift_out <= 1'b0;
        repeat (8) @(posedge clk);
        tx_shift_out <= 1'b1;
        repeat (4) @(posedge clk);
        peer_low <= drive;
        repeat (t_pre) @(posedge clk);
        rd(SAB_OFS_CTL, rd_val);
        chk8(rd_val & 8'h24, 8'h04);
        repeat (t_post) @(posedge clk);
        rd(SAB_OFS_CTL, rd_val);
        chk8(rd_val & 8'h20, {2'h0, drive, 5'h00});
        peer_low <= 1'b0;
        tx_shift_out <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        chk8({7'h00, tx_pin}, {7'h00, drive});
        wr(SAB_OFS_CTL, ctl);
        rd(SAB_OFS_CTL, rd_val);
        chk8(rd_val & 8'h20, {2'h0, drive, 5'h00});
        wr(SAB_OFS_CTL, 8'h00);
        rd(SAB_OFS_CTL, rd_val);
        chk8(rd_val, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        chk8({7'h00, tx_pin}, 8'h00);
        tx_shift_out <= 1'b1;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        errors++;
        finish_test();
    end

    initial begin
        rows = '{
            '{SAB_OFS_CTL, 8'hff, SAB_OFS_CTL, 8'hd0, 1'b0},
            '{SAB_OFS_CTL, 8'h3f, SAB_OFS_CTL, 8'h10, 1'b0},
            '{SAB_OFS_CTL, 8'h40, SAB_OFS_CTL, 8'h40, 1'b0},
            '{SAB_OFS_CTL, 8'h80, SAB_OFS_CTL, 8'h80, 1'b0},
            '{SAB_OFS_CTL, 8'h50, SAB_OFS_CTL, 8'h50, 1'b0},
            '{SAB_OFS_CFG, 8'h01, SAB_OFS_CFG, 8'h01, 1'b1},
            '{SAB_OFS_CNT, 8'hff, SAB_OFS_CNT, 8'h00, 1'b1},
            '{2'h3, 8'hff, 2'h3, 8'h00, 1'b1},
            '{SAB_OFS_CFG, 8'h00, SAB_OFS_CFG, 8'h00, 1'b0}
        };
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wdata);
            rd(rows[i].raddr, rd_val);
            chk8(rd_val, rows[i].exp);
            chk8({7'h00, prescaler_src_sel}, {7'h00, rows[i].psrc});
        end
        // Plain, past the msb, and past the wrap
        meas0(400, 100, 1'b0);
        meas0(1200, 300, 1'b0);
        meas0(2400, 88, 1'b1);
        wr(SAB_OFS_CTL, 8'h40);
        rdcnt(cnt_val);
        chk8(rd_val, 8'h40);
        chkr(cnt_val, 0, 0);
        // Line already low when enabled: counting starts at once
        peer_low <= 1'b1;
        repeat (6) @(posedge clk);
        wr(SAB_OFS_CTL, 8'h50);
        repeat (600) @(posedge clk);
        peer_low <= 1'b0;
        repeat (10) @(posedge clk);
        rdcnt(cnt_val);
        chk8(rd_val, 8'h58);
        chkr(cnt_val, 98, 102);
        peer_low <= 1'b1;
        wr(SAB_OFS_CTL, 8'h00);
        repeat (100) @(posedge clk);
        rdcnt(cnt_val);
        chk8(rd_val, 8'h00);
        chkr(cnt_val, 0, 0);
        peer_low <= 1'b0;
        arb(8'h80, 200, 30, 1'b1);
        arb(8'h90, 30, 30, 1'b1);
        arb(8'h80, 200, 30, 1'b0);
        // Own echo cut off so only the early transmit fall is seen
        hear_tx <= 1'b0;
        wr(SAB_OFS_CTL, 8'h80);
        tx_shift_out <= 1'b0;
        repeat (8) @(posedge clk);
        tx_shift_out <= 1'b1;
        repeat (40) @(posedge clk);
        tx_shift_out <= 1'b0;
        repeat (20) @(posedge clk);
        rdcnt(cnt_val);
        chk8(rd_val & 8'h24, 8'h00);
        chkr(cnt_val, 0, 0);
        tx_shift_out <= 1'b1;
        repeat (40) @(posedge clk);
        rdcnt(cnt_val);
        chk8(rd_val & 8'h24, 8'h04);
        chkr(cnt_val, 8, 13);
        hear_tx <= 1'b1;
        // Second reset while a measurement waits for the line
        wr(SAB_OFS_CFG, 8'h01);
        wr(SAB_OFS_CTL, 8'h50);
        nrst <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk8(reg_rdata, 8'h00);
        chk8({6'h00, tx_pin, prescaler_src_sel}, 8'h02);
        @(posedge clk);
        nrst <= 1'b1;
        for (int a = 0; a < 3; a++) begin
            rd(a[1:0], rd_val);
            chk8(rd_val, 8'h00);
        end
        finish_test();
    end
endmodule
